// ---- verif/mgmt_serial_port_dual_tb.sv ----
// Self-checking bench for the station and device pair
`timescale 1ns/1ns
module mgmt_serial_port_dual_tb;
    import mspd_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wb_cyc, wb_stb, wb_we, wb_ack, synced, dual_write, wr_stb;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    logic [15:0] status_a, status_b, wr_data, d1, d2;
    logic [1:0]  wr_ports;
    logic [4:0]  wr_reg;
    logic [31:0] exp_q[$];
    int          miscompares = 0;
    int          check_count = 0;
    integer      seed = 32'h17ea;
    always #2 clk = ~clk;
    mspd_mgmt_if i_mspd_mgmt_if ();
    mspd_station #(.MDC_HALF(5)) i_mspd_station (.clk, .rst, .mgmt(i_mspd_mgmt_if), .wb_cyc,
        .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack);
    mspd_device i_mspd_device (.clk, .rst, .mgmt(i_mspd_mgmt_if), .port_a_addr(5'h01),
        .port_b_addr(5'h02), .status_a, .status_b, .synced, .dual_write, .wr_stb, .wr_ports,
        .wr_reg, .wr_data);
    mspd_link_sva i_mspd_link_sva (.clk, .rst, .mdc(i_mspd_mgmt_if.mdc),
        .sta_mdio_o(i_mspd_mgmt_if.sta_mdio_o), .sta_mdio_oe(i_mspd_mgmt_if.sta_mdio_oe),
        .dev_mdio_o(i_mspd_mgmt_if.dev_mdio_o), .dev_mdio_oe(i_mspd_mgmt_if.dev_mdio_oe),
        .mdio(i_mspd_mgmt_if.mdio));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= d;
        wb_sel <= 4'hf;
        do @(posedge clk); while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    // Ctl bits: go, read, preamble
    task automatic frame(input logic [2:0] ctl, input logic [4:0] dev, input logic [4:0] rg,
                         input logic [15:0] d);
        wb(1'b1, WB_ADDR, {22'h0, dev, rg});
        wb(1'b1, WB_WDATA, {16'h0, d});
        wb(1'b1, WB_CTRL, {29'h0, ctl});
        do wb(1'b0, WB_STATUS, 32'h0); while (rd[STAT_BUSY] !== 1'b1);
        do wb(1'b0, WB_STATUS, 32'h0); while (rd[STAT_BUSY] !== 1'b0);
    endtask
    task automatic rdchk(input logic [4:0] dev, input logic [4:0] rg, input logic [15:0] d);
        frame(3'h3, dev, rg, 16'h0000);
        chk(rd & 32'h0003_FFFF, {16'h0, d});
    endtask
    // Each write strobe takes the oldest note
    always @(posedge clk) begin
        if (wr_stb === 1'b1)
            chk({9'h0, wr_ports, wr_reg, wr_data}, exp_q.size() ? exp_q.pop_front() : '1);
    end
    initial begin
        #200000;
        miscompares++;
        results;
    end
    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = '0;
        status_a = $random(seed);
        status_b = $random(seed);
        d1 = $random(seed);
        d2 = $random(seed);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        frame(3'h1, 5'h01, 5'h02, d1);
        chk({31'h0, synced}, 32'h0);
        exp_q.push_back({9'h0, 2'b01, 5'h02, d1});
        frame(3'h5, 5'h01, 5'h02, d1);
        chk({31'h0, synced}, 32'h1);
        rdchk(5'h01, 5'h02, d1);
        rdchk(5'h01, 5'h01, status_a | 16'h0040);
        rdchk(5'h02, 5'h01, status_b | 16'h0040);
        exp_q.push_back({9'h0, 2'b01, 5'h17, 16'h8000});
        frame(3'h1, 5'h01, 5'h17, 16'h8000);
        chk({31'h0, dual_write}, 32'h1);
        exp_q.push_back({9'h0, 2'b11, 5'h03, d2});
        frame(3'h1, 5'h01, 5'h03, d2);
        rdchk(5'h02, 5'h03, d2);
        rdchk(5'h02, 5'h02, 16'h0000);
        rdchk(5'h01, 5'h02, d1);
        frame(3'h1, 5'h09, 5'h03, d1);
        frame(3'h3, 5'h09, 5'h02, 16'h0000);
        chk(rd & 32'h0002_0000, 32'h0002_0000);
        exp_q.push_back({9'h0, 2'b11, 5'h17, 16'h0000});
        frame(3'h1, 5'h01, 5'h17, 16'h0000);
        chk({31'h0, dual_write}, 32'h0);
        chk(exp_q.size(), 32'h0);
        results;
    end
endmodule

// ---- verif/mspd_link_sva.sv ----
// Protocol checks on the management link between station and device
`timescale 1ns/1ns
module mspd_link_sva (
    input wire logic clk,         // System clock
    input wire logic rst,         // Async reset
    input wire logic mdc,         // Management clock
    input wire logic sta_mdio_o,  // Station data
    input wire logic sta_mdio_oe, // Station enable
    input wire logic dev_mdio_o,  // Device data
    input wire logic dev_mdio_oe, // Device enable
    input wire logic mdio         // Resolved line
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [8:0] drv_cnt_reg;
    // Length of each device drive burst
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            drv_cnt_reg <= 9'h000;
        else if (!dev_mdio_oe)
            drv_cnt_reg <= 9'h000;
        else
            drv_cnt_reg <= drv_cnt_reg + 9'h001;
    end
    a_no_contention: assert property (!(sta_mdio_oe && dev_mdio_oe))
        else $error("both ends drive the line");
    a_idle_pullup: assert property (!sta_mdio_oe && !dev_mdio_oe |-> mdio)
        else $error("released line not high");
    a_turn_zero: assert property ($rose(dev_mdio_oe) |-> !dev_mdio_o)
        else $error("second turnaround bit not zero");
    a_turn_release: assert property ($rose(dev_mdio_oe) |-> !$past(sta_mdio_oe, 5))
        else $error("station still drove first turnaround bit");
    a_read_length: assert property ($fell(dev_mdio_oe) |-> drv_cnt_reg inside {[166:174]})
        else $error("device drive not seventeen bits long");
    a_sta_on_fall: assert property ($changed(sta_mdio_o) |-> !mdc)
        else $error("station data changed while clock high");
    a_dev_on_rise: assert property ($changed(dev_mdio_oe) |-> mdc)
        else $error("device enable changed while clock low");
    a_mdc_half: assert property ($rose(mdc) |-> mdc[*5] ##1 !mdc)
        else $error("management clock half period wrong");
endmodule

// ---- verilog/mspd_device.sv ----
// Dual-port management slave with two register blocks
//
`timescale 1ns/1ns
module mspd_device (
    input  wire logic                           clk,          // System clock
    input  wire logic                           rst,          // Async reset, active high
    mspd_mgmt_if.device                         mgmt,         // Management link
    input  wire logic [mspd_pkg::ADDR_W-1:0]    port_a_addr,  // Device address of port A
    input  wire logic [mspd_pkg::ADDR_W-1:0]    port_b_addr,  // Device address of port B
    input  wire logic [mspd_pkg::DATA_W-1:0]    status_a,     // Link status of port A
    input  wire logic [mspd_pkg::DATA_W-1:0]    status_b,     // Link status of port B
    output logic                                synced,       // Preamble seen, frames taken
    output logic                                dual_write,   // Dual write mode active
    output logic                                wr_stb,       // Register write pulse
    output logic [mspd_pkg::NUM_PORTS-1:0]      wr_ports,     // Ports written
    output logic [mspd_pkg::ADDR_W-1:0]         wr_reg,       // Register written
    output logic [mspd_pkg::DATA_W-1:0]         wr_data       // Data written
);
    import mspd_pkg::*;

    typedef enum logic [2:0] {
        D_UNSYNC,
        D_IDLE,
        D_START,
        D_OP,
        D_ADDR,
        D_TA1,
        D_TA2,
        D_DATA
    } mspd_dstate_type;

    mspd_dstate_type            state_reg;
    logic [5:0]                 cnt_reg;
    logic [DATA_W-1:0]          sh_reg;
    logic                       is_read_reg;
    logic [2*ADDR_W-1:0]        addr_reg;
    logic [DATA_W-1:0]          regs_reg [NUM_PORTS][NUM_REGS];
    logic [DATA_W-1:0]          rd_sh_reg;
    logic                       dev_o_reg;
    logic                       dev_oe_reg;
    logic                       mdc_s1;
    logic                       mdc_s2;
    logic                       mdc_s3;
    logic                       mdio_s1;
    logic                       mdio_s2;
    logic                       mdc_rise;
    logic                       bit_in;
    logic [ADDR_W-1:0]          phy_sel;
    logic [ADDR_W-1:0]          reg_sel;
    logic                       hit_a;
    logic                       hit_b;
    logic [DATA_W-1:0]          wr_word;
    logic                       commit;

    // Pick status or stored word of the addressed port only
    function automatic logic [DATA_W-1:0] read_word(input logic port_b,
                                                    input logic [ADDR_W-1:0] r);
        logic [DATA_W-1:0] v;
        v = REG_RESET;
        if (r == REG_LINK_STATUS) begin
            v = (port_b ? status_b : status_a) | PRE_SUPPR_MASK;
        end else begin
            v = regs_reg[port_b][r];
        end
        return v;
    endfunction

    // Two-stage synchronisers; third stage only for edge finding
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mdc_s1  <= 1'b0;
            mdc_s2  <= 1'b0;
            mdc_s3  <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
        end else begin
            mdc_s1  <= mgmt.mdc;
            mdc_s2  <= mdc_s1;
            mdc_s3  <= mdc_s2;
            mdio_s1 <= mgmt.mdio;
            mdio_s2 <= mdio_s1;
        end
    end

    assign mdc_rise = mdc_s2 && !mdc_s3;
    assign bit_in   = mdio_s2;
    assign phy_sel  = addr_reg[2*ADDR_W-1:ADDR_W];
    assign reg_sel  = addr_reg[ADDR_W-1:0];
    assign hit_a    = (phy_sel == port_a_addr);
    assign hit_b    = (phy_sel == port_b_addr);
    assign wr_word  = {sh_reg[DATA_W-2:0], bit_in};
    assign commit   = mdc_rise && (state_reg == D_DATA) && !is_read_reg
                      && (cnt_reg == 6'(DATA_W - 1));

    // Frame decoder
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg   <= D_UNSYNC;
            cnt_reg     <= 6'h00;
            sh_reg      <= REG_RESET;
            is_read_reg <= 1'b0;
            addr_reg    <= '0;
        end else if (mdc_rise) begin
            sh_reg <= wr_word;
            case (state_reg)
                D_UNSYNC: begin
                    if (bit_in) begin
                        if (cnt_reg != 6'(PREAMBLE_LEN)) begin
                            cnt_reg <= cnt_reg + 6'h01;
                        end
                    end else if (cnt_reg == 6'(PREAMBLE_LEN)) begin
                        state_reg <= D_START;
                    end else begin
                        cnt_reg <= 6'h00;
                    end
                end
                D_IDLE: begin
                    if (!bit_in) begin
                        state_reg <= D_START;
                    end
                end
                D_START: begin
                    cnt_reg <= 6'h00;
                    if (bit_in) begin
                        state_reg <= D_OP;
                    end else begin
                        state_reg <= D_UNSYNC;
                    end
                end
                D_OP: begin
                    if (cnt_reg == 6'h01) begin
                        cnt_reg <= 6'h00;
                        if ({sh_reg[0], bit_in} == OP_READ) begin
                            is_read_reg <= 1'b1;
                            state_reg   <= D_ADDR;
                        end else if ({sh_reg[0], bit_in} == OP_WRITE) begin
                            is_read_reg <= 1'b0;
                            state_reg   <= D_ADDR;
                        end else begin
                            state_reg <= D_UNSYNC;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 6'h01;
                    end
                end
                D_ADDR: begin
                    if (cnt_reg == 6'(2 * ADDR_W - 1)) begin
                        addr_reg  <= {sh_reg[2*ADDR_W-2:0], bit_in};
                        state_reg <= D_TA1;
                        cnt_reg   <= 6'h00;
                    end else begin
                        cnt_reg <= cnt_reg + 6'h01;
                    end
                end
                D_TA1: begin
                    if (bit_in) begin
                        state_reg <= D_TA2;
                    end else begin
                        state_reg <= D_UNSYNC;
                    end
                end
                D_TA2: begin
                    if (!is_read_reg && bit_in) begin
                        state_reg <= D_UNSYNC;
                    end else begin
                        state_reg <= D_DATA;
                        cnt_reg   <= 6'h00;
                    end
                end
                D_DATA: begin
                    if (cnt_reg == 6'(DATA_W - 1)) begin
                        state_reg <= D_IDLE;
                        cnt_reg   <= 6'h00;
                    end else begin
                        cnt_reg <= cnt_reg + 6'h01;
                    end
                end
                default: begin
                    state_reg <= D_UNSYNC;
                    cnt_reg   <= 6'h00;
                end
            endcase
        end
    end

    // Read answer driver
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dev_o_reg  <= 1'b1;
            dev_oe_reg <= 1'b0;
            rd_sh_reg  <= REG_RESET;
        end else if (mdc_rise) begin
            if (state_reg == D_TA1 && bit_in && is_read_reg && (hit_a || hit_b)) begin
                dev_oe_reg <= 1'b1;
                dev_o_reg  <= 1'b0;
                rd_sh_reg  <= read_word(!hit_a, reg_sel);
            end else if (dev_oe_reg && (state_reg == D_TA2 ||
                         (state_reg == D_DATA && cnt_reg != 6'(DATA_W - 1)))) begin
                dev_o_reg <= rd_sh_reg[DATA_W-1];
                rd_sh_reg <= {rd_sh_reg[DATA_W-2:0], 1'b0};
            end else begin
                dev_oe_reg <= 1'b0;
                dev_o_reg  <= 1'b1;
            end
        end
    end

    // Register blocks of both ports
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int r = 0; r < NUM_REGS; r++) begin
                    regs_reg[p][r] <= REG_RESET;
                end
            end
            wr_stb   <= 1'b0;
            wr_ports <= '0;
            wr_reg   <= '0;
            wr_data  <= REG_RESET;
        end else begin
            wr_stb <= 1'b0;
            if (commit && (hit_a || hit_b) && reg_sel != REG_LINK_STATUS) begin
                wr_stb  <= 1'b1;
                wr_reg  <= reg_sel;
                wr_data <= wr_word;
                wr_ports <= {hit_b || (hit_a && dual_write), hit_a};
                if (hit_a) begin
                    regs_reg[0][reg_sel] <= wr_word;
                end
                if (hit_b || (hit_a && dual_write)) begin
                    regs_reg[1][reg_sel] <= wr_word;
                end
            end
        end
    end

    assign dual_write       = regs_reg[0][REG_BYPASS_CTRL][BIT_DUAL_WRITE];
    assign synced           = (state_reg != D_UNSYNC);
    assign mgmt.dev_mdio_o  = dev_o_reg;
    assign mgmt.dev_mdio_oe = dev_oe_reg;
endmodule

// ---- verilog/mspd_mgmt_if.sv ----
// Management clock and shared data line between station and device
`timescale 1ns/1ns
interface mspd_mgmt_if;
    logic mdc;
    logic sta_mdio_o;
    logic sta_mdio_oe;
    logic dev_mdio_o;
    logic dev_mdio_oe;
    logic mdio;

    // Pull-up holds the line high unless someone drives zero
    assign mdio = !((sta_mdio_oe && !sta_mdio_o) || (dev_mdio_oe && !dev_mdio_o));

    modport station (output mdc, output sta_mdio_o, output sta_mdio_oe, input mdio);
    modport device  (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe);
endinterface

// ---- verilog/mspd_pkg.sv ----
// Shared constants of the dual-port management serial link
// How it works
// - Station clocks management line at most 25 MHz
// - Shared data line, up to 32 devices
// - Thirty-two ones synchronise the port first
// - Preamble may be driven or pulled up
// - Resync with 32 ones after bad field
// - Ignore all frames until preamble seen
// - Stay synced until reset or bad field
// - Frame starts with zero then one
// - Nobody drives first read turnaround bit
// - Device drives zero, then sixteen data bits
// - Station writes turnaround as one, zero
// - Status register bit 6 reads one
// - Skip preamble only if all support it
// - At least one idle bit between frames
// - Port A bit 15 enables dual write
// - Dual write copies port A writes into port B block
// - Reads return only addressed port data
// - Thirty-two 16-bit registers per port
package mspd_pkg;
    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 5;
    localparam int          NUM_REGS        = 32;
    localparam int          NUM_PORTS       = 2;
    localparam int          MAX_DEVICES     = 32;
    localparam int          PREAMBLE_LEN    = 32;
    localparam int          FRAME_LEN       = 64;
    localparam int          TA_FIRST_IDX    = 17;
    localparam logic [1:0]  START_CODE      = 2'h1;
    localparam logic [1:0]  OP_WRITE        = 2'h1;
    localparam logic [1:0]  OP_READ         = 2'h2;
    localparam logic [1:0]  TA_WRITE        = 2'h2;
    localparam logic [1:0]  TA_READ         = 2'h3;
    localparam logic [4:0]  REG_LINK_STATUS = 5'h01;
    localparam logic [4:0]  REG_BYPASS_CTRL = 5'h17;
    localparam int          BIT_PRE_SUPPR   = 6;
    localparam int          BIT_DUAL_WRITE  = 15;
    localparam logic [15:0] PRE_SUPPR_MASK  = 16'h0040;
    localparam logic [15:0] REG_RESET       = 16'h0000;
    localparam longint      CLK_HZ          = 250_000_000;
    localparam longint      MDC_MAX_HZ      = 25_000_000;
    localparam int          MDC_HALF_CYCLES = int'((CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ));
    localparam int          WB_ADR_W        = 8;
    localparam logic [7:0]  WB_CTRL         = 8'h00;
    localparam logic [7:0]  WB_ADDR         = 8'h04;
    localparam logic [7:0]  WB_WDATA        = 8'h08;
    localparam logic [7:0]  WB_STATUS       = 8'h0C;
    localparam int          CTRL_GO         = 0;
    localparam int          CTRL_READ       = 1;
    localparam int          CTRL_PREAMBLE   = 2;
    localparam int          STAT_BUSY       = 16;
    localparam int          STAT_NO_ANSWER  = 17;
endpackage

// ---- verilog/mspd_station.sv ----
// Station manager: Wishbone-driven management frame master
`timescale 1ns/1ns
module mspd_station #(
    parameter int MDC_HALF = mspd_pkg::MDC_HALF_CYCLES  // Clocks per half management period
) (
    input  wire logic                           clk,       // System clock
    input  wire logic                           rst,       // Async reset, active high
    mspd_mgmt_if.station                        mgmt,      // Management link
    input  wire logic                           wb_cyc,    // Wishbone cycle
    input  wire logic                           wb_stb,    // Wishbone strobe
    input  wire logic                           wb_we,     // Wishbone write enable
    input  wire logic [mspd_pkg::WB_ADR_W-1:0]  wb_adr,    // Wishbone byte address
    input  wire logic [3:0]                     wb_sel,    // Wishbone byte selects
    input  wire logic [31:0]                    wb_dat_w,  // Wishbone write data
    output logic [31:0]                         wb_dat_r,  // Wishbone read data
    output logic                                wb_ack     // Wishbone acknowledge
);
    import mspd_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_RUN, S_GAP} mspd_sstate_type;

    mspd_sstate_type            state_reg;
    logic [7:0]                 div_reg;
    logic                       mdc_reg;
    logic [5:0]                 idx_reg;
    logic [FRAME_LEN-1:0]       frame_reg;
    logic                       rd_reg;
    logic                       o_reg;
    logic                       oe_reg;
    logic [DATA_W-1:0]          rdata_reg;
    logic                       no_ans_reg;
    logic                       go_pend_reg;
    logic                       cfg_read_reg;
    logic                       cfg_pre_reg;
    logic [2*ADDR_W-1:0]        cfg_addr_reg;
    logic [DATA_W-1:0]          cfg_wdata_reg;
    logic                       mdio_s1;
    logic                       mdio_s2;
    logic                       wb_acc;
    logic                       wb_wr;
    logic                       go_wr;
    logic                       start;
    logic                       tick;
    logic                       rise_evt;
    logic                       fall_evt;

    assign tick     = (div_reg == 8'(MDC_HALF - 1));
    assign rise_evt = tick && !mdc_reg;
    assign fall_evt = tick && mdc_reg;
    assign wb_acc   = wb_cyc && wb_stb && !wb_ack;
    // Writes land at the edge that sees ack high
    assign wb_wr    = wb_cyc && wb_stb && wb_ack && wb_we;
    assign go_wr    = wb_wr && wb_adr == WB_CTRL && wb_sel[0] && wb_dat_w[CTRL_GO];
    assign start    = go_pend_reg && state_reg == S_IDLE && fall_evt;

    // Clock divider, never above the line's limit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= 8'h00;
            mdc_reg <= 1'b0;
        end else if (tick) begin
            div_reg <= 8'h00;
            mdc_reg <= !mdc_reg;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
        end else begin
            mdio_s1 <= mgmt.mdio;
            mdio_s2 <= mdio_s1;
        end
    end

    // Frame sequencer: drive after falling edge, sample at rising
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg  <= S_IDLE;
            idx_reg    <= 6'h00;
            frame_reg  <= '0;
            rd_reg     <= 1'b0;
            o_reg      <= 1'b1;
            oe_reg     <= 1'b0;
            rdata_reg  <= REG_RESET;
            no_ans_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (start) begin
                        frame_reg <= {{PREAMBLE_LEN{1'b1}}, START_CODE,
                                      cfg_read_reg ? OP_READ : OP_WRITE, cfg_addr_reg,
                                      cfg_read_reg ? TA_READ : TA_WRITE, cfg_wdata_reg};
                        idx_reg    <= cfg_pre_reg ? 6'(FRAME_LEN - 1) : 6'(FRAME_LEN - 1 - PREAMBLE_LEN);
                        rd_reg     <= cfg_read_reg;
                        no_ans_reg <= 1'b0;
                        state_reg  <= S_RUN;
                        // First bit goes out on this falling edge
                        o_reg      <= cfg_pre_reg ? 1'b1 : START_CODE[1];
                        oe_reg     <= 1'b1;
                    end
                end
                S_RUN: begin
                    if (fall_evt) begin
                        o_reg  <= frame_reg[idx_reg];
                        oe_reg <= !(rd_reg && idx_reg <= 6'(TA_FIRST_IDX));
                    end else if (rise_evt) begin
                        if (rd_reg && idx_reg == 6'(DATA_W)) begin
                            no_ans_reg <= mdio_s2;
                        end
                        if (rd_reg && idx_reg < 6'(DATA_W)) begin
                            rdata_reg <= {rdata_reg[DATA_W-2:0], mdio_s2};
                        end
                        if (idx_reg == 6'h00) begin
                            state_reg <= S_GAP;
                        end else begin
                            idx_reg <= idx_reg - 6'h01;
                        end
                    end
                end
                S_GAP: begin
                    if (fall_evt) begin
                        oe_reg <= 1'b0;
                        o_reg  <= 1'b1;
                    end else if (rise_evt) begin
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Pending start; a go while pending or busy is ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            go_pend_reg <= 1'b0;
        end else if (go_wr && state_reg == S_IDLE && !go_pend_reg) begin
            go_pend_reg <= 1'b1;
        end else if (start) begin
            go_pend_reg <= 1'b0;
        end
    end

    // Wishbone slave, one wait state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack        <= 1'b0;
            wb_dat_r      <= 32'h0000_0000;
            cfg_read_reg  <= 1'b0;
            cfg_pre_reg   <= 1'b1;
            cfg_addr_reg  <= '0;
            cfg_wdata_reg <= REG_RESET;
        end else begin
            wb_ack <= wb_acc;
            if (wb_wr && wb_adr == WB_CTRL && wb_sel[0] && state_reg == S_IDLE && !go_pend_reg) begin
                cfg_read_reg <= wb_dat_w[CTRL_READ];
                cfg_pre_reg  <= wb_dat_w[CTRL_PREAMBLE];
            end
            if (wb_wr && wb_adr == WB_ADDR && wb_sel[0]) begin
                cfg_addr_reg[7:0] <= wb_dat_w[7:0];
            end
            if (wb_wr && wb_adr == WB_ADDR && wb_sel[1]) begin
                cfg_addr_reg[2*ADDR_W-1:8] <= wb_dat_w[2*ADDR_W-1:8];
            end
            if (wb_wr && wb_adr == WB_WDATA && wb_sel[0]) begin
                cfg_wdata_reg[7:0] <= wb_dat_w[7:0];
            end
            if (wb_wr && wb_adr == WB_WDATA && wb_sel[1]) begin
                cfg_wdata_reg[15:8] <= wb_dat_w[15:8];
            end
            if (wb_acc && !wb_we) begin
                case (wb_adr)
                    WB_CTRL:   wb_dat_r <= 32'({cfg_pre_reg, cfg_read_reg, 1'b0});
                    WB_ADDR:   wb_dat_r <= 32'(cfg_addr_reg);
                    WB_WDATA:  wb_dat_r <= 32'(cfg_wdata_reg);
                    WB_STATUS: wb_dat_r <= 32'({no_ans_reg,
                                                (state_reg != S_IDLE) || go_pend_reg,
                                                rdata_reg});
                    default:   wb_dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign mgmt.mdc         = mdc_reg;
    assign mgmt.sta_mdio_o  = o_reg;
    assign mgmt.sta_mdio_oe = oe_reg;
endmodule
